// ### ddr3_cmd_pkg.sv
package ddr3_cmd_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int BANKS  = 8;
  localparam int BA_W   = 3;
  localparam int ADDR_W = 16;
  localparam int COL_W  = 10;
  localparam int DQ_W   = 16;
  localparam int MASK_W = 2;
  localparam int MODE_REGS = 4;
  // pin vector: cke, cs, ras, cas, we, ba, addr, odt, dq, mask
  localparam int PIN_W  = 5 + BA_W + ADDR_W + 1 + DQ_W + MASK_W;

  // ----------------------------------------------------------------
  // address bit roles
  // ----------------------------------------------------------------
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  // ----------------------------------------------------------------
  // mode word fields
  // ----------------------------------------------------------------
  localparam int MR_BURST   = 0;
  localparam int MR_POSTED  = 1;
  localparam int BL_LSB     = 0;
  localparam int AL_LSB     = 3;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [ADDR_W-1:0] MODE_RESET = 16'h0000;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TRP_NS   = 15;
  localparam int TRAS_NS  = 35;
  localparam int TRTP_NS  = 8;

  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] TRP_CYC  = 4'(min_cycles(TRP_NS));
  localparam logic [3:0] TRAS_CYC = 4'(min_cycles(TRAS_NS));
  localparam logic [3:0] TRTP_CYC = 4'(min_cycles(TRTP_NS));

  // ----------------------------------------------------------------
  // commands and power states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    CMD_DESEL = 9'h001,
    CMD_NOP   = 9'h002,
    CMD_MODE  = 9'h004,
    CMD_REF   = 9'h008,
    CMD_PRE   = 9'h010,
    CMD_ACT   = 9'h020,
    CMD_WR    = 9'h040,
    CMD_RD    = 9'h080,
    CMD_CAL   = 9'h100
  } cmd_e;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'h1,
    PWR_DOWN   = 3'h2,
    PWR_SELF   = 3'h4
  } pwr_e;

endpackage

// ### ddr3_command_protocol.sv
`timescale 1ns/10ps
// Notes on behaviour
// - commands decode from cs, ras, cas, we and cke at the rising edge
// - read and write bursts always complete; burst mode set by mode word
// - no refresh performed while in power-down
// - decoding ignores termination input; termination off during self-refresh
// - no-operation registers nothing and leaves running bursts alone
// - chip unselected ignores new commands, in-progress work finishes
// - row open picks bank and row; row stays open until precharge
// - read bursts from open row; A10 high closes the row afterwards
// - write bursts to open row; A10 high closes the row afterwards
// - masked write bytes are discarded, unmasked bytes stored
// - precharge closes one bank or all by A10; reopen after tRP
// - precharge to idle or precharging bank acts as no-operation
// - read auto-precharge starts posted delay plus tRTP after command
// - write auto-precharge waits for last data and tRAS lockout
// - each refresh needs its own command; row address internal
// - self-refresh entry shuts DLL and termination; exit restores them
// - calibration long or short by A10, taken even with banks open
// - A12 on read or write in on-the-fly mode: high full eight beats, low chopped four
// - bank inputs pick which of four mode words is loaded
module ddr3_command_protocol
  import ddr3_cmd_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              RESET_N,
  input  wire logic              CKE,
  input  wire logic              CS_N,
  input  wire logic              RAS_N,
  input  wire logic              CAS_N,
  input  wire logic              WE_N,
  input  wire logic [BA_W-1:0]   BA,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic              TERMINATION_ENABLE,
  input  wire logic [DQ_W-1:0]   WDATA,
  input  wire logic [MASK_W-1:0] WRITE_BYTE_MASK,
  output logic [BANKS-1:0]       BANK_OPEN,
  output logic [BANKS-1:0]       BANK_PRECHARGING,
  output logic                   BURST_ACTIVE,
  output logic                   ARRAY_WE,
  output logic                   ARRAY_RE,
  output logic [BA_W-1:0]        ARRAY_BANK,
  output logic [ADDR_W-1:0]      ARRAY_ROW,
  output logic [COL_W-1:0]       ARRAY_COL,
  output logic [DQ_W-1:0]        ARRAY_WDATA,
  output logic [MASK_W-1:0]      ARRAY_BYTE_EN,
  output logic                   REFRESH_PULSE,
  output logic [ADDR_W-1:0]      REFRESH_ROW,
  output logic                   SELF_REFRESH,
  output logic                   POWER_DOWN,
  output logic                   DLL_ENABLE,
  output logic                   DLL_RESET,
  output logic                   TERM_ACTIVE,
  output logic                   CAL_LONG,
  output logic                   CAL_SHORT,
  output logic [ADDR_W-1:0]      MODE_WORD0,
  output logic [ADDR_W-1:0]      MODE_WORD1,
  output logic [ADDR_W-1:0]      MODE_WORD2,
  output logic [ADDR_W-1:0]      MODE_WORD3
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic cmd_e decode_cmd(input logic [3:0] c);
    case (c)
      4'h0:    return CMD_MODE;
      4'h1:    return CMD_REF;
      4'h2:    return CMD_PRE;
      4'h3:    return CMD_ACT;
      4'h4:    return CMD_WR;
      4'h5:    return CMD_RD;
      4'h6:    return CMD_CAL;
      4'h7:    return CMD_NOP;
      default: return CMD_DESEL;
    endcase
  endfunction

  function automatic logic [3:0] dec4(input logic [3:0] v);
    return (v != 4'h0) ? v - 4'h1 : 4'h0;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic             rstn_s1_reg;
  logic             rstn_s2_reg;
  logic             rst;

  always_ff @(posedge CLK)
  begin
    pin_s1_reg  <= {CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR,
                    TERMINATION_ENABLE, WDATA, WRITE_BYTE_MASK};
    pin_s2_reg  <= pin_s1_reg;
    rstn_s1_reg <= RESET_N;
    rstn_s2_reg <= rstn_s1_reg;
  end

  // reset pin is unclocked; it is resynchronised before use
  assign rst = SYS_RST | ~rstn_s2_reg;

  logic              cke_s;
  logic [3:0]        ctl_s;
  logic [BA_W-1:0]   ba_s;
  logic [ADDR_W-1:0] addr_s;
  logic              odt_s;
  logic [DQ_W-1:0]   dq_s;
  logic [MASK_W-1:0] mask_s;

  assign {cke_s, ctl_s, ba_s, addr_s, odt_s, dq_s, mask_s} = pin_s2_reg;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  cmd_e              cmd;
  pwr_e              pwr_reg;
  pwr_e              pwr_next;
  logic              cke_prev_reg;
  logic              run;
  logic              self_entry;
  logic              pd_entry;
  logic              wake;

  // termination input never enters the decode
  assign cmd  = decode_cmd(ctl_s);
  // a chip-unselected cycle decodes like a no-operation: no action
  assign run  = (pwr_reg == PWR_ACTIVE) && cke_prev_reg && cke_s;
  assign self_entry = (pwr_reg == PWR_ACTIVE) && cke_prev_reg && !cke_s
                      && (cmd == CMD_REF);
  assign pd_entry   = (pwr_reg == PWR_ACTIVE) && cke_prev_reg && !cke_s
                      && (cmd != CMD_REF);
  // in self-refresh every input except cke is ignored
  assign wake = (pwr_reg != PWR_ACTIVE) && cke_s;

  always_comb
  begin
    case (pwr_reg)
      PWR_ACTIVE: pwr_next = self_entry ? PWR_SELF
                           : (pd_entry ? PWR_DOWN : PWR_ACTIVE);
      PWR_DOWN:   pwr_next = wake ? PWR_ACTIVE : PWR_DOWN;
      PWR_SELF:   pwr_next = wake ? PWR_ACTIVE : PWR_SELF;
      default:    pwr_next = PWR_ACTIVE;
    endcase
  end

  // ----------------------------------------------------------------
  // bank state
  // ----------------------------------------------------------------
  logic [BANKS-1:0]  open_reg;
  logic [BANKS-1:0]  open_next;
  logic [BANKS-1:0]  prech_reg;
  logic [BANKS-1:0]  act_sel;
  logic [BANKS-1:0]  close_sel;
  logic [3:0]        pre_cnt_reg [BANKS];
  logic [3:0]        pre_cnt_next [BANKS];
  logic [3:0]        ras_cnt_reg [BANKS];
  logic [ADDR_W-1:0] row_reg [BANKS];
  logic              apc_pending_reg;
  logic              apc_armed_reg;
  logic [BA_W-1:0]   apc_bank_reg;
  logic [3:0]        apc_cnt_reg;
  logic              apc_fire;
  logic              all_idle;

  // no restore may be cut short by an auto-precharge
  assign apc_fire = apc_pending_reg && apc_armed_reg && (apc_cnt_reg == 4'h0)
                    && (ras_cnt_reg[apc_bank_reg] == 4'h0);
  assign all_idle = (open_reg == '0) && (prech_reg == '0);

  always_comb
  begin
    for (int i = 0; i < BANKS; i++)
    begin
      // only a closed bank past tRP may open
      act_sel[i]   = run && (cmd == CMD_ACT) && (ba_s == BA_W'(i))
                     && !open_reg[i] && (pre_cnt_reg[i] == 4'h0);
      // a closed or closing bank has no open row: nothing happens
      close_sel[i] = open_reg[i] && ((run && (cmd == CMD_PRE)
                     && (addr_s[AP_BIT] || ba_s == BA_W'(i)))
                     || (apc_fire && apc_bank_reg == BA_W'(i)));
      open_next[i] = act_sel[i] | (open_reg[i] & ~close_sel[i]);
      pre_cnt_next[i] = close_sel[i] ? TRP_CYC : dec4(pre_cnt_reg[i]);
    end
  end

  always_ff @(posedge CLK)
  begin
    for (int i = 0; i < BANKS; i++)
    begin
      if (rst)
      begin
        pre_cnt_reg[i] <= 4'h0;
        ras_cnt_reg[i] <= 4'h0;
        row_reg[i]     <= '0;
      end
      else
      begin
        pre_cnt_reg[i] <= pre_cnt_next[i];
        ras_cnt_reg[i] <= act_sel[i] ? TRAS_CYC : dec4(ras_cnt_reg[i]);
        row_reg[i]     <= act_sel[i] ? addr_s : row_reg[i];
        prech_reg[i]   <= pre_cnt_next[i] != 4'h0;
      end
    end
    if (rst)
    begin
      open_reg  <= '0;
      prech_reg <= '0;
    end
    else
      open_reg  <= open_next;
  end

  // ----------------------------------------------------------------
  // bursts
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] mode_reg [MODE_REGS];
  logic              rw_take;
  logic              chop;
  logic [1:0]        bl_mode;
  logic              burst_reg;
  logic              burst_wr_reg;
  logic [BA_W-1:0]   burst_bank_reg;
  logic [COL_W-1:0]  burst_col_reg;
  logic [3:0]        beat_reg;
  logic [3:0]        beats_reg;
  logic              last_beat;
  logic [3:0]        posted;

  // one burst and one auto-precharge in flight; others are dropped
  assign rw_take = run && (cmd == CMD_RD || cmd == CMD_WR) && open_reg[ba_s]
                   && !burst_reg && !apc_pending_reg;
  assign bl_mode = mode_reg[MR_BURST][BL_LSB +: 2];
  assign chop    = (bl_mode == BL_FIXED4)
                   || (bl_mode == BL_OTF && !addr_s[BC_BIT]);
  assign last_beat = burst_reg && (beat_reg == beats_reg - 4'h1);
  assign posted  = {2'h0, mode_reg[MR_POSTED][AL_LSB +: 2]};

  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      burst_reg       <= 1'b0;
      burst_wr_reg    <= 1'b0;
      burst_bank_reg  <= '0;
      burst_col_reg   <= '0;
      beat_reg        <= 4'h0;
      beats_reg       <= BEATS_FULL;
      apc_pending_reg <= 1'b0;
      apc_armed_reg   <= 1'b0;
      apc_bank_reg    <= '0;
      apc_cnt_reg     <= 4'h0;
    end
    else
    begin
      if (rw_take)
      begin
        burst_reg      <= 1'b1;
        burst_wr_reg   <= (cmd == CMD_WR);
        burst_bank_reg <= ba_s;
        burst_col_reg  <= addr_s[COL_W-1:0];
        beat_reg       <= 4'h0;
        beats_reg      <= chop ? BEATS_CHOP : BEATS_FULL;
        apc_pending_reg <= addr_s[AP_BIT];
        apc_armed_reg  <= (cmd == CMD_RD);
        apc_bank_reg   <= ba_s;
        // the closing edge itself is the last count, hence one less
        apc_cnt_reg    <= posted + TRTP_CYC - 4'h1;
      end
      else
      begin
        // nothing but the last beat ends a burst
        burst_reg <= burst_reg && !last_beat;
        beat_reg  <= burst_reg ? beat_reg + 4'h1 : beat_reg;
        if (last_beat && burst_wr_reg)
        begin
          apc_armed_reg <= 1'b1;
          apc_cnt_reg   <= 4'h0;
        end
        else if (apc_armed_reg)
          apc_cnt_reg <= dec4(apc_cnt_reg);
        if (apc_fire)
          apc_pending_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // array strobes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      ARRAY_WE      <= 1'b0;
      ARRAY_RE      <= 1'b0;
      ARRAY_BANK    <= '0;
      ARRAY_ROW     <= '0;
      ARRAY_COL     <= '0;
      ARRAY_WDATA   <= '0;
      ARRAY_BYTE_EN <= '0;
    end
    else
    begin
      ARRAY_WE      <= burst_reg && burst_wr_reg;
      ARRAY_RE      <= burst_reg && !burst_wr_reg;
      ARRAY_BANK    <= burst_bank_reg;
      ARRAY_ROW     <= row_reg[burst_bank_reg];
      ARRAY_COL     <= burst_col_reg + COL_W'(beat_reg);
      ARRAY_WDATA   <= dq_s;
      ARRAY_BYTE_EN <= ~mask_s;
    end
  end

  // ----------------------------------------------------------------
  // refresh, power, calibration, mode words
  // ----------------------------------------------------------------
  logic ref_take;

  // not run in power-down, so no refresh happens there
  assign ref_take = run && (cmd == CMD_REF) && all_idle;

  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      pwr_reg       <= PWR_ACTIVE;
      cke_prev_reg  <= 1'b0;
      REFRESH_PULSE <= 1'b0;
      REFRESH_ROW   <= '0;
      DLL_ENABLE    <= 1'b1;
      DLL_RESET     <= 1'b0;
      TERM_ACTIVE   <= 1'b0;
      CAL_LONG      <= 1'b0;
      CAL_SHORT     <= 1'b0;
      for (int m = 0; m < MODE_REGS; m++)
        mode_reg[m] <= MODE_RESET;
    end
    else
    begin
      pwr_reg       <= pwr_next;
      cke_prev_reg  <= cke_s;
      REFRESH_PULSE <= ref_take;
      REFRESH_ROW   <= REFRESH_ROW + ADDR_W'(ref_take);
      DLL_ENABLE    <= pwr_next != PWR_SELF;
      DLL_RESET     <= (pwr_reg == PWR_SELF) && wake;
      TERM_ACTIVE   <= odt_s && (pwr_next != PWR_SELF);
      CAL_LONG      <= run && (cmd == CMD_CAL) && addr_s[AP_BIT];
      CAL_SHORT     <= run && (cmd == CMD_CAL) && !addr_s[AP_BIT];
      if (run && (cmd == CMD_MODE) && !ba_s[BA_W-1])
        mode_reg[ba_s[1:0]] <= addr_s;
    end
  end

  assign BANK_OPEN        = open_reg;
  assign BANK_PRECHARGING = prech_reg;
  assign BURST_ACTIVE     = burst_reg;
  assign SELF_REFRESH     = pwr_reg[2];
  assign POWER_DOWN       = pwr_reg[1];
  assign MODE_WORD0       = mode_reg[0];
  assign MODE_WORD1       = mode_reg[1];
  assign MODE_WORD2       = mode_reg[2];
  assign MODE_WORD3       = mode_reg[3];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (rst);

  property p_burst_runs;
    burst_reg && !last_beat |=> burst_reg && beat_reg == $past(beat_reg) + 4'h1;
  endproperty
  a_burst_runs: assert property (p_burst_runs)
    else $error("burst stopped early");

  property p_desel_quiet;
    cmd == CMD_DESEL && !apc_pending_reg |=> open_reg == $past(open_reg);
  endproperty
  a_desel_quiet: assert property (p_desel_quiet)
    else $error("deselect changed bank state");

  property p_self_off;
    self_entry |=> SELF_REFRESH && !DLL_ENABLE && !TERM_ACTIVE;
  endproperty
  a_self_off: assert property (p_self_off)
    else $error("self-refresh entry left dll or termination on");

  property p_term_self;
    SELF_REFRESH |-> !TERM_ACTIVE;
  endproperty
  a_term_self: assert property (p_term_self)
    else $error("termination active in self-refresh");

  property p_pd_no_ref;
    POWER_DOWN |=> !REFRESH_PULSE;
  endproperty
  a_pd_no_ref: assert property (p_pd_no_ref)
    else $error("refresh during power-down");

  property p_pre_idle;
    run && cmd == CMD_PRE && !open_reg[ba_s] && !prech_reg[ba_s]
      && !apc_fire |=> !prech_reg[$past(ba_s)];
  endproperty
  a_pre_idle: assert property (p_pre_idle)
    else $error("precharge of idle bank not ignored");

  property p_apc_lock;
    apc_fire |=> !open_reg[$past(apc_bank_reg)] && prech_reg[$past(apc_bank_reg)]
      && $past(ras_cnt_reg[apc_bank_reg]) == 4'h0;
  endproperty
  a_apc_lock: assert property (p_apc_lock)
    else $error("auto-precharge broke tRAS lockout");

  property p_mode_load;
    run && cmd == CMD_MODE && ba_s == 3'h2 |=> MODE_WORD2 == $past(addr_s);
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("mode word not loaded");

  property p_wr_mask;
    burst_reg && burst_wr_reg && mask_s == 2'h3 |=> ARRAY_WE
      && ARRAY_BYTE_EN == 2'h0;
  endproperty
  a_wr_mask: assert property (p_wr_mask)
    else $error("masked bytes enabled");

  property p_chop_len;
    rw_take && bl_mode == BL_OTF && !addr_s[BC_BIT] |=> burst_reg [*4] ##1 !burst_reg;
  endproperty
  a_chop_len: assert property (p_chop_len)
    else $error("chopped burst length wrong");

  c_read:  cover property (rw_take && cmd == CMD_RD ##1 burst_reg [*8]);
  c_write: cover property (rw_take && cmd == CMD_WR && addr_s[AP_BIT]);
  c_self:  cover property (self_entry ##[1:20] DLL_RESET);
  c_ref:   cover property (REFRESH_PULSE);

endmodule

// ### ddr3_ctrl_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// controller model: command, address and write data pins
// ------------------------------------------------------------
module ddr3_ctrl_model
  import ddr3_cmd_pkg::*;
(
  input  wire logic        CLK,
  output logic             CKE,
  output logic             CS_N,
  output logic             RAS_N,
  output logic             CAS_N,
  output logic             WE_N,
  output logic [BA_W-1:0]  BA,
  output logic [ADDR_W-1:0] ADDR,
  output logic             TERMINATION_ENABLE,
  output logic [DQ_W-1:0]  WDATA,
  output logic [MASK_W-1:0] WRITE_BYTE_MASK
);
  logic              cke_hold;
  logic [DQ_W-1:0]   d [8];
  logic [MASK_W-1:0] m [8];

  initial
  begin
    cke_hold = 1'b1;
    CKE = 1'b1;
    {CS_N, RAS_N, CAS_N, WE_N} = 4'h7;
    BA = '0;
    ADDR = '0;
    TERMINATION_ENABLE = 1'b0;
    WDATA = '0;
    WRITE_BYTE_MASK = '0;
  end

  // ------------------------------------------------------------
  // one command, driven just after the edge, held until replaced
  // ------------------------------------------------------------
  task automatic cmd(input cmd_e c, input logic [BA_W-1:0] b,
                     input logic [ADDR_W-1:0] a);
    @(posedge CLK);
    #1;
    CKE = cke_hold;
    BA = b;
    ADDR = a;
    case (c)
      CMD_DESEL: {CS_N, RAS_N, CAS_N, WE_N} = 4'hb;
      CMD_MODE:  {CS_N, RAS_N, CAS_N, WE_N} = 4'h0;
      CMD_REF:   {CS_N, RAS_N, CAS_N, WE_N} = 4'h1;
      CMD_PRE:   {CS_N, RAS_N, CAS_N, WE_N} = 4'h2;
      CMD_ACT:   {CS_N, RAS_N, CAS_N, WE_N} = 4'h3;
      CMD_WR:    {CS_N, RAS_N, CAS_N, WE_N} = 4'h4;
      CMD_RD:    {CS_N, RAS_N, CAS_N, WE_N} = 4'h5;
      CMD_CAL:   {CS_N, RAS_N, CAS_N, WE_N} = 4'h6;
      default:   {CS_N, RAS_N, CAS_N, WE_N} = 4'h7;
    endcase
  endtask

  // idle cycles: address lines carry noise since they are don't-care;
  // beat k of write data goes out k+1 edges after the command
  task automatic run(input int n);
    for (int k = 0; k < n; k++)
    begin
      @(posedge CLK);
      #1;
      CKE = cke_hold;
      {CS_N, RAS_N, CAS_N, WE_N} = 4'h7;
      BA = 3'($urandom);
      ADDR = 16'($urandom);
      TERMINATION_ENABLE = 1'($urandom);
      WDATA = (k < 8) ? d[k] : ~WDATA;
      WRITE_BYTE_MASK = (k < 8) ? m[k] : ~WRITE_BYTE_MASK;
    end
  endtask
endmodule

// ### ddr3_command_protocol_tb.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// bench for the command decoder
// ------------------------------------------------------------
module ddr3_command_protocol_tb
  import ddr3_cmd_pkg::*;
  ;
  logic CLK, SYS_RST, RESET_N, CKE, CS_N, RAS_N, CAS_N, WE_N;
  logic TERMINATION_ENABLE, BURST_ACTIVE, ARRAY_WE, ARRAY_RE;
  logic REFRESH_PULSE, SELF_REFRESH, POWER_DOWN, DLL_ENABLE;
  logic DLL_RESET, TERM_ACTIVE, CAL_LONG, CAL_SHORT;
  logic [BA_W-1:0]   BA, ARRAY_BANK, b, ob;
  logic [ADDR_W-1:0] ADDR, ARRAY_ROW, REFRESH_ROW, er, r0, mw [5];
  logic [ADDR_W-1:0] MODE_WORD0, MODE_WORD1, MODE_WORD2, MODE_WORD3;
  logic [DQ_W-1:0]   WDATA, ARRAY_WDATA;
  logic [MASK_W-1:0] WRITE_BYTE_MASK, ARRAY_BYTE_EN;
  logic [BANKS-1:0]  BANK_OPEN, BANK_PRECHARGING, pre_seen;
  logic [COL_W-1:0]  ARRAY_COL, bc;
  int errors, compares, n_re, n_we, n_ref, n_cl, n_cs, n_dr, k;

  ddr3_command_protocol uut (.*);
  ddr3_ctrl_model ctl (.*);

  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] col_word(
      input logic [COL_W-1:0] c, input logic ap, input logic full);
    return ADDR_W'(c) | (ADDR_W'(ap) << AP_BIT) | (ADDR_W'(full) << BC_BIT);
  endfunction

  // sequential order, wraps inside the column field
  function automatic logic [COL_W-1:0] beat_col(
      input logic [COL_W-1:0] c, input int n);
    return COL_W'(c + n);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic clr();
    n_re = 0;
    n_we = 0;
    n_ref = 0;
    n_cl = 0;
    n_cs = 0;
    n_dr = 0;
    pre_seen = '0;
  endtask

  task automatic watch(input int n);
    repeat (n)
    begin
      @(posedge CLK);
      #2;
      if (ARRAY_RE === 1'b1)
      begin
        chk(ARRAY_COL, beat_col(bc, n_re));
        chk({ARRAY_BANK, ARRAY_ROW}, {b, er});
        n_re++;
      end
      if (ARRAY_WE === 1'b1)
      begin
        chk(ARRAY_COL, beat_col(bc, n_we));
        chk(ARRAY_WDATA, ctl.d[n_we[2:0]]);
        chk(ARRAY_BYTE_EN, 2'(~ctl.m[n_we[2:0]]));
        n_we++;
      end
      n_ref += int'(REFRESH_PULSE === 1'b1);
      n_cl += int'(CAL_LONG === 1'b1);
      n_cs += int'(CAL_SHORT === 1'b1);
      n_dr += int'(DLL_RESET === 1'b1);
      pre_seen = pre_seen | BANK_PRECHARGING;
    end
  endtask

  task automatic idle(input int n);
    fork
      ctl.run(n);
      watch(n);
    join
  endtask

  task automatic go(input cmd_e c, input logic [BA_W-1:0] ba,
                    input logic [ADDR_W-1:0] a, input int n);
    clr();
    ctl.cmd(c, ba, a);
    idle(n);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    SYS_RST = 1'b1;
    RESET_N = 1'b1;
    errors = 0;
    compares = 0;
    void'($urandom(32'h2eb37752));
    repeat (10) @(posedge CLK);
    #1 SYS_RST = 1'b0;
    chk(BANK_OPEN, 8'h00);
    chk(DLL_ENABLE, 1'b1);
    chk(MODE_WORD0, MODE_RESET);
    $display("test reset done");
    // per-command burst length, posted delay of 2; fifth load is refused
    mw[0] = 16'(BL_OTF);
    mw[1] = 16'h0010;
    for (int i = 2; i < 5; i++)
      mw[i] = 16'($urandom);
    for (int i = 0; i < 5; i++)
      go(CMD_MODE, 3'(i), mw[i], 5);
    chk(MODE_WORD0, mw[0]);
    chk(MODE_WORD1, mw[1]);
    chk(MODE_WORD2, mw[2]);
    chk(MODE_WORD3, mw[3]);
    $display("test mode words done");
    b = 3'($urandom);
    ob = b + 3'h1;
    er = 16'($urandom);
    bc = 10'($urandom);
    go(CMD_DESEL, b, er, 5);
    chk(BANK_OPEN, 8'h00);
    go(CMD_NOP, b, er, 5);
    chk(BANK_OPEN, 8'h00);
    go(CMD_ACT, b, er, 5);
    chk(BANK_OPEN, 8'(1 << b));
    go(CMD_ACT, b, ~er, 5);
    ctl.cmd(CMD_RD, b, col_word(bc, 1'b0, 1'b1));
    go(CMD_RD, b, col_word(~bc, 1'b0, 1'b1), 16);
    chk(n_re, 8);
    go(CMD_RD, b, col_word(bc, 1'b0, 1'b0), 12);
    chk(n_re, 4);
    chk(BANK_OPEN, 8'(1 << b));
    $display("test reads done");
    for (int i = 0; i < 8; i++)
    begin
      ctl.d[i] = 16'($urandom);
      ctl.m[i] = 2'($urandom);
    end
    ctl.m[0] = 2'h0;
    ctl.m[1] = 2'h3;
    go(CMD_WR, b, col_word(bc, 1'b0, 1'b0), 12);
    chk(n_we, 4);
    go(CMD_WR, b, col_word(bc, 1'b1, 1'b0), 4);
    chk(BANK_OPEN[b], 1'b1);
    idle(10);
    chk(BANK_OPEN[b], 1'b0);
    chk(n_we, 4);
    $display("test writes done");
    go(CMD_PRE, ob, 16'h0000, 6);
    chk(pre_seen[ob], 1'b0);
    go(CMD_ACT, b, er, 5);
    go(CMD_PRE, b, 16'h0000, 6);
    chk(pre_seen[b], 1'b1);
    chk(BANK_OPEN, 8'h00);
    go(CMD_ACT, b, er, 5);
    go(CMD_ACT, ob, er, 5);
    go(CMD_PRE, 3'($urandom), 16'(1 << AP_BIT), 6);
    chk(BANK_OPEN, 8'h00);
    go(CMD_MODE, 3'h0, 16'(BL_FIXED4), 5);
    go(CMD_ACT, b, er, 5);
    go(CMD_RD, b, col_word(bc, 1'b0, 1'b1), 12);
    chk(n_re, 4);
    go(CMD_PRE, b, 16'h0000, 5);
    go(CMD_MODE, 3'h0, mw[0], 5);
    $display("test precharge done");
    go(CMD_ACT, b, er, 5);
    clr();
    ctl.cmd(CMD_RD, b, col_word(bc, 1'b1, 1'b1));
    k = 0;
    while (BANK_OPEN[b] === 1'b1 && k < 40)
    begin
      idle(1);
      k++;
    end
    if (k >= 40)
    begin
      errors++;
      results();
    end
    chk(k, 3 + 32'(mw[1][AL_LSB +: 2]) + 32'(TRTP_CYC));
    chk(BURST_ACTIVE, 1'b1);
    idle(12);
    chk(n_re, 8);
    chk(BURST_ACTIVE, 1'b0);
    $display("test auto close done");
    r0 = REFRESH_ROW;
    go(CMD_REF, 3'($urandom), 16'($urandom), 6);
    chk(n_ref, 1);
    chk(REFRESH_ROW, 16'(r0 + 1));
    go(CMD_CAL, b, 16'(1 << AP_BIT), 5);
    chk(32'(n_cl * 4 + n_cs), 4);
    go(CMD_CAL, b, 16'h0000, 5);
    chk(32'(n_cl * 4 + n_cs), 1);
    $display("test refresh and calibration done");
    ctl.cke_hold = 1'b0;
    go(CMD_NOP, b, er, 6);
    chk(POWER_DOWN, 1'b1);
    go(CMD_REF, b, er, 6);
    chk(n_ref, 0);
    ctl.cke_hold = 1'b1;
    idle(6);
    chk(POWER_DOWN, 1'b0);
    ctl.cke_hold = 1'b0;
    go(CMD_REF, b, er, 6);
    chk(SELF_REFRESH, 1'b1);
    chk(DLL_ENABLE, 1'b0);
    go(CMD_ACT, b, er, 6);
    chk(TERM_ACTIVE, 1'b0);
    chk(BANK_OPEN, 8'h00);
    ctl.cke_hold = 1'b1;
    clr();
    idle(8);
    chk(SELF_REFRESH, 1'b0);
    chk(DLL_ENABLE, 1'b1);
    chk(n_dr, 1);
    idle(512);
    $display("test power states done");
    go(CMD_ACT, b, er, 5);
    chk(BANK_OPEN, 8'(1 << b));
    @(posedge CLK) #1 RESET_N = 1'b0;
    idle(5);
    @(posedge CLK) #1 RESET_N = 1'b1;
    chk(BANK_OPEN, 8'h00);
    chk(MODE_WORD1, MODE_RESET);
    $display("test reset pin done");
    results();
  end
endmodule
